// >>> shared/dma_seq_pkg.sv
// constants and types shared by the dma channel sequencer
package dma_seq_pkg;
  localparam int NUM_CH = 6;
  localparam int CH_W = 3;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BURST_W = 5;
  localparam int XFER_W = 16;
  localparam int STEP_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = ADDR_W + DATA_W;
  localparam logic [CH_W-1:0] FIRST_CH = 3'h0;
  localparam logic [CH_W-1:0] LAST_CH = 3'h5;
  localparam logic [CH_W-1:0] RESET_CH = 3'h0;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 22'h0;
  localparam logic [XFER_W-1:0] RESET_COUNT = 16'h0;
  localparam logic [BURST_W-1:0] RESET_WORDS = 5'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ISSUE = 2'h1,
    ST_CAPTURE = 2'h3,
    ST_FINISH = 2'h2
  } seq_state_t;
endpackage

// >>> src/dma_data_fifo.sv
// data fifo between the read side and the write side of the sequencer
`timescale 1ns/1ps
module dma_data_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
    logic valid;
    logic [WIDTH-1:0] data;
  } fifo_t;
  fifo_t s;
  fifo_t next_s;
  logic push;
  logic pop;

  always_comb begin
    next_s = s;
    push = in_valid && (s.count < (PW+1)'(DEPTH));
    // the output register refills only when empty or drained
    pop = (s.count != '0) && (!s.valid || out_ready);
    if (out_ready) begin
      next_s.valid = 1'b0;
    end
    if (pop) begin
      next_s.valid = 1'b1;
      next_s.data = s.mem[s.rd];
      next_s.rd = s.rd + 1'b1;
    end
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = s.wr + 1'b1;
    end
    next_s.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // one slot held back: the producer pushes two cycles after it looks at ready
  assign in_ready = s.count < (PW+1)'(DEPTH - 1);

  AST_FIFO_NO_DROP: assert property (
    @(posedge clock) disable iff (rst) in_valid |-> s.count < (PW+1)'(DEPTH))
    else $error("word pushed into a full fifo");
  assign out_valid = s.valid;
  assign out_data = s.data;
endmodule // dma_data_fifo

// >>> src/dma_channel_picker.sv
// picks the next channel to serve from the pending set
`timescale 1ns/1ps
module dma_channel_picker
  import dma_seq_pkg::*;
(
  input wire logic [NUM_CH-1:0] req,
  input wire logic [CH_W-1:0] last,
  input wire logic preempt_mode,
  output logic any,
  output logic [CH_W-1:0] pick
);
  logic [CH_W-1:0] idx;

  always_comb begin
    any = 1'b0;
    pick = RESET_CH;
    idx = last;
    // circular scan starting after the last served channel
    for (int k = 0; k < NUM_CH; k++) begin
      idx = (idx == LAST_CH) ? FIRST_CH : idx + 3'h1;
      if (!any && req[idx] && !(preempt_mode && idx == FIRST_CH)) begin
        any = 1'b1;
        pick = idx;
      end
    end
    if (preempt_mode && req[FIRST_CH]) begin
      any = 1'b1;
      pick = FIRST_CH;
    end
  end
endmodule // dma_channel_picker

// >>> src/dma_channel_sequencer.sv
// six channel dma sequencer: priority, burst and transfer loops, addressing
// Operation
// - first channel preempts others after current word
// - resume suspended channel burst after preemption
// - channels two to six rotate equally
// - no pending work returns to idle
// - one burst per trigger, up to 32
// - transfer runs programmed count plus one bursts
// - one interrupt per transfer, start or end
// - default: one burst then next channel
// - whole job: one trigger runs all bursts
// - transfer start copies shadow pointers to active
// - add signed word step after each word
// - add burst step unless wrapping
// - independent wrap after wrap-length plus one bursts
// - wrap: step base, then load pointer
// - wrap reloads its countdown
// - base pointers load at transfer start
// - shadows only used at transfer start
// - word countdown loads, decrements, ends at zero
// - no auto rearm clears active flag
// - wrap countdowns load at transfer start
`timescale 1ns/1ps
module dma_channel_sequencer
  import dma_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic preempt_mode,
  input wire logic [NUM_CH-1:0] trigger,
  input wire logic [NUM_CH-1:0] run_set,
  input wire logic [NUM_CH-1:0] whole_job_per_trigger,
  input wire logic [NUM_CH-1:0] auto_rearm,
  input wire logic [NUM_CH-1:0] irq_enable,
  input wire logic [NUM_CH-1:0] irq_at_start_select,
  input wire logic [NUM_CH-1:0][BURST_W-1:0] burst_size,
  input wire logic [NUM_CH-1:0][XFER_W-1:0] transfer_size,
  input wire logic [NUM_CH-1:0][XFER_W-1:0] read_wrap_size,
  input wire logic [NUM_CH-1:0][XFER_W-1:0] write_wrap_size,
  input wire logic [NUM_CH-1:0][STEP_W-1:0] read_word_step,
  input wire logic [NUM_CH-1:0][STEP_W-1:0] write_word_step,
  input wire logic [NUM_CH-1:0][STEP_W-1:0] read_burst_step,
  input wire logic [NUM_CH-1:0][STEP_W-1:0] write_burst_step,
  input wire logic [NUM_CH-1:0][STEP_W-1:0] read_wrap_step,
  input wire logic [NUM_CH-1:0][STEP_W-1:0] write_wrap_step,
  input wire logic [NUM_CH-1:0][ADDR_W-1:0] shadow_read_pointer,
  input wire logic [NUM_CH-1:0][ADDR_W-1:0] shadow_write_pointer,
  input wire logic [NUM_CH-1:0][ADDR_W-1:0] shadow_read_circle_base_pointer,
  input wire logic [NUM_CH-1:0][ADDR_W-1:0] shadow_write_circle_base_pointer,
  output logic [NUM_CH-1:0] channel_active_flag,
  output logic [NUM_CH-1:0] irq,
  output logic mem_rd_en,
  output logic [ADDR_W-1:0] mem_rd_addr,
  input wire logic [DATA_W-1:0] mem_rd_data,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [ADDR_W-1:0] mem_wr_addr,
  output logic [DATA_W-1:0] mem_wr_data
);
  typedef struct packed {
    seq_state_t state;
    logic [CH_W-1:0] cur;
    logic [CH_W-1:0] rr_last;
    logic susp_valid;
    logic [CH_W-1:0] susp_ch;
    logic [NUM_CH-1:0] pending;
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0] in_burst;
    logic [NUM_CH-1:0] in_xfer;
    logic [NUM_CH-1:0][BURST_W-1:0] word_cnt;
    logic [NUM_CH-1:0][XFER_W-1:0] xfer_cnt;
    logic [NUM_CH-1:0][XFER_W-1:0] rd_wrap_cnt;
    logic [NUM_CH-1:0][XFER_W-1:0] wr_wrap_cnt;
    logic [NUM_CH-1:0][ADDR_W-1:0] read_pointer;
    logic [NUM_CH-1:0][ADDR_W-1:0] write_pointer;
    logic [NUM_CH-1:0][ADDR_W-1:0] read_circle_base_pointer;
    logic [NUM_CH-1:0][ADDR_W-1:0] write_circle_base_pointer;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] cap_waddr;
    logic push;
    logic last_word;
    logic [NUM_CH-1:0] irq;
  } seq_t;
  seq_t s;
  seq_t next_s;
  logic [NUM_CH-1:0] req;
  logic pick_any;
  logic [CH_W-1:0] pick_ch;
  logic fifo_in_ready;
  logic go;
  logic [CH_W-1:0] go_ch;
  logic start_xfer;
  logic preempt_now;
  logic xfer_done;
  logic [ADDR_W-1:0] shadow_sel;

  function automatic logic [ADDR_W-1:0] ext(input logic [STEP_W-1:0] v);
    return {{(ADDR_W-STEP_W){v[STEP_W-1]}}, v};
  endfunction

  assign req = s.pending & s.active;
  assign shadow_sel = shadow_read_pointer[go_ch];

  dma_channel_picker i_dma_channel_picker (
    .req(req),
    .last(s.rr_last),
    .preempt_mode(preempt_mode),
    .any(pick_any),
    .pick(pick_ch)
  );

  dma_data_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) i_dma_data_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(s.push),
    .in_ready(fifo_in_ready),
    .in_data({s.cap_waddr, mem_rd_data}),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data({mem_wr_addr, mem_wr_data})
  );

  always_comb begin
    next_s = s;
    next_s.irq = '0;
    next_s.rd_en = 1'b0;
    next_s.push = 1'b0;
    go = 1'b0;
    go_ch = s.cur;
    start_xfer = 1'b0;
    preempt_now = preempt_mode && s.cur != FIRST_CH && s.pending[FIRST_CH]
                  && s.active[FIRST_CH] && !s.last_word;
    xfer_done = s.xfer_cnt[s.cur] == RESET_COUNT;
    case (s.state)
      ST_IDLE: begin
        go = pick_any;
        go_ch = pick_ch;
      end
      ST_ISSUE: begin
        // a full fifo stalls the read side
        if (fifo_in_ready) begin
          next_s.rd_en = 1'b1;
          next_s.rd_addr = s.read_pointer[s.cur];
          next_s.cap_waddr = s.write_pointer[s.cur];
          next_s.read_pointer[s.cur] = s.read_pointer[s.cur] + ext(read_word_step[s.cur]);
          next_s.write_pointer[s.cur] = s.write_pointer[s.cur] + ext(write_word_step[s.cur]);
          next_s.last_word = s.word_cnt[s.cur] == RESET_WORDS;
          if (s.word_cnt[s.cur] != RESET_WORDS) begin
            next_s.word_cnt[s.cur] = s.word_cnt[s.cur] - 5'h1;
          end
          next_s.state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        next_s.push = 1'b1;
        if (s.last_word) begin
          next_s.state = ST_FINISH;
        end else if (preempt_now) begin
          next_s.susp_valid = 1'b1;
          next_s.susp_ch = s.cur;
          go = 1'b1;
          go_ch = FIRST_CH;
        end else begin
          next_s.state = ST_ISSUE;
        end
      end
      ST_FINISH: begin
        next_s.in_burst[s.cur] = 1'b0;
        if (s.rd_wrap_cnt[s.cur] == RESET_COUNT) begin
          // base steps first, then pointer follows
          next_s.read_circle_base_pointer[s.cur] =
            s.read_circle_base_pointer[s.cur] + ext(read_wrap_step[s.cur]);
          next_s.read_pointer[s.cur] = next_s.read_circle_base_pointer[s.cur];
          next_s.rd_wrap_cnt[s.cur] = read_wrap_size[s.cur];
        end else begin
          next_s.read_pointer[s.cur] = s.read_pointer[s.cur] + ext(read_burst_step[s.cur]);
          next_s.rd_wrap_cnt[s.cur] = s.rd_wrap_cnt[s.cur] - 16'h1;
        end
        // write side wraps on its own count
        if (s.wr_wrap_cnt[s.cur] == RESET_COUNT) begin
          // base steps first, then pointer follows
          next_s.write_circle_base_pointer[s.cur] =
            s.write_circle_base_pointer[s.cur] + ext(write_wrap_step[s.cur]);
          next_s.write_pointer[s.cur] = next_s.write_circle_base_pointer[s.cur];
          next_s.wr_wrap_cnt[s.cur] = write_wrap_size[s.cur];
        end else begin
          next_s.write_pointer[s.cur] = s.write_pointer[s.cur] + ext(write_burst_step[s.cur]);
          next_s.wr_wrap_cnt[s.cur] = s.wr_wrap_cnt[s.cur] - 16'h1;
        end
        if (xfer_done) begin
          next_s.in_xfer[s.cur] = 1'b0;
          next_s.irq[s.cur] = irq_enable[s.cur] && !irq_at_start_select[s.cur];
          if (!auto_rearm[s.cur]) begin
            next_s.active[s.cur] = 1'b0;
            next_s.pending[s.cur] = 1'b0;
          end
        end else begin
          next_s.xfer_cnt[s.cur] = s.xfer_cnt[s.cur] - 16'h1;
        end
        if (s.susp_valid && s.cur == FIRST_CH) begin
          next_s.susp_valid = 1'b0;
          next_s.cur = s.susp_ch;
          next_s.state = ST_ISSUE;
        end else if (whole_job_per_trigger[s.cur] && !xfer_done) begin
          // keep going without a new trigger
          go = 1'b1;
          go_ch = s.cur;
        end else begin
          // hand over to the next pending channel
          // a channel just disabled gets no new burst
          go = pick_any && !(pick_ch == s.cur && !next_s.active[s.cur]);
          go_ch = pick_ch;
          next_s.state = ST_IDLE;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
    if (go) begin
      next_s.state = ST_ISSUE;
      next_s.cur = go_ch;
      // rotation ignores the first channel in preempt mode
      if (!(preempt_mode && go_ch == FIRST_CH)) begin
        next_s.rr_last = go_ch;
      end
      next_s.pending[go_ch] = 1'b0;
      next_s.in_burst[go_ch] = 1'b1;
      // load word countdown at burst start
      next_s.word_cnt[go_ch] = burst_size[go_ch];
      if (!s.in_xfer[go_ch]) begin
        start_xfer = 1'b1;
        next_s.in_xfer[go_ch] = 1'b1;
        next_s.xfer_cnt[go_ch] = transfer_size[go_ch];
        next_s.rd_wrap_cnt[go_ch] = read_wrap_size[go_ch];
        next_s.wr_wrap_cnt[go_ch] = write_wrap_size[go_ch];
        next_s.read_pointer[go_ch] = shadow_read_pointer[go_ch];
        next_s.write_pointer[go_ch] = shadow_write_pointer[go_ch];
        next_s.read_circle_base_pointer[go_ch] = shadow_read_circle_base_pointer[go_ch];
        next_s.write_circle_base_pointer[go_ch] = shadow_write_circle_base_pointer[go_ch];
        next_s.irq[go_ch] = irq_enable[go_ch] && irq_at_start_select[go_ch];
      end
    end
    // a trigger or run request in the clearing cycle still wins
    next_s.active = next_s.active | run_set;
    next_s.pending = next_s.pending | (trigger & s.active);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign channel_active_flag = s.active;
  assign irq = s.irq;
  assign mem_rd_en = s.rd_en;
  assign mem_rd_addr = s.rd_addr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_PREEMPT_SWITCH: assert property (
    s.state == ST_CAPTURE && preempt_now |=> s.state == ST_ISSUE && s.cur == FIRST_CH
      && s.susp_valid)
    else $error("first channel did not preempt after the word");
  AST_RESUME: assert property (
    s.state == ST_FINISH && s.cur == FIRST_CH && s.susp_valid
      |=> s.cur == $past(s.susp_ch) && s.state == ST_ISSUE && !s.susp_valid)
    else $error("suspended channel not resumed");
  AST_ROTATE: assert property (
    preempt_mode && req != '0 && !req[FIRST_CH] |-> pick_any && pick_ch != FIRST_CH
      && req[pick_ch])
    else $error("rotation picked an invalid channel");
  AST_IDLE_RETURN: assert property (
    s.state == ST_FINISH && !pick_any && !s.susp_valid
      && !(whole_job_per_trigger[s.cur] && !xfer_done) |=> s.state == ST_IDLE)
    else $error("sequencer did not return to idle");
  AST_LAST_WORD: assert property (
    s.state == ST_ISSUE && fifo_in_ready && s.word_cnt[s.cur] == RESET_WORDS
      |=> s.last_word ##1 s.state == ST_FINISH)
    else $error("burst did not end at zero count");
  AST_SHADOW_LOAD: assert property (
    start_xfer |=> s.write_pointer[s.cur] == $past(shadow_write_pointer[go_ch])
      && s.read_pointer[s.cur] == $past(shadow_sel))
    else $error("active pointer not loaded from shadow");
  AST_WORD_STEP: assert property (
    s.state == ST_ISSUE && fifo_in_ready |=> mem_rd_en
      && s.read_pointer[s.cur] == s.rd_addr + ext(read_word_step[s.cur]))
    else $error("word step not applied");
  AST_WRAP_LOAD: assert property (
    s.state == ST_FINISH && s.rd_wrap_cnt[s.cur] == RESET_COUNT
      |=> s.read_pointer[$past(s.cur)] == s.read_circle_base_pointer[$past(s.cur)])
    else $error("wrap did not load base into pointer");
  AST_ACTIVE_CLEAR: assert property (
    s.state == ST_FINISH && xfer_done && !auto_rearm[s.cur] && !run_set[s.cur]
      |=> !s.active[$past(s.cur)])
    else $error("active flag kept after transfer");
  AST_STALL: assert property (
    s.state == ST_ISSUE && !fifo_in_ready |=> !mem_rd_en && s.state == ST_ISSUE)
    else $error("read issued into a full fifo");

  COV_PREEMPT: cover property (s.state == ST_CAPTURE && preempt_now);
  COV_WRAP: cover property (s.state == ST_FINISH && s.rd_wrap_cnt[s.cur] == RESET_COUNT);
  COV_IDLE: cover property (s.state == ST_FINISH ##1 s.state == ST_IDLE);
  COV_FULL: cover property (s.state == ST_ISSUE && !fifo_in_ready);
endmodule // dma_channel_sequencer

// >>> testbench/dma_mem_model.sv
// synchronous memory and write sink on the far side of the sequencer
`timescale 1ns/1ps
module dma_mem_model
  import dma_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire logic hold,
  input wire logic mem_rd_en,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  output logic [DATA_W-1:0] mem_rd_data,
  output logic mem_wr_ready
);
  logic [1:0] tick;
  // data is valid only the cycle after the strobe; stale data keeps flipping
  always_ff @(posedge clock) begin
    tick <= rst ? 2'h0 : tick + 2'h1;
    if (mem_rd_en) begin
      mem_rd_data <= mem_rd_addr[DATA_W-1:0] ^ 16'hA5C3;
    end else begin
      mem_rd_data <= rst ? 16'h0 : ~mem_rd_data;
    end
  end
  // sink stalls fully, or accepts one word in four when slow
  assign mem_wr_ready = !hold && (!slow || tick == 2'h3);
endmodule // dma_mem_model

// >>> testbench/testbench.sv
// self-checking bench for the dma channel sequencer
`timescale 1ns/1ps
module testbench
  import dma_seq_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, preempt_mode = 1'b0, slow = 1'b0, hold = 1'b0;
  logic [NUM_CH-1:0] trigger, run_set, whole_job_per_trigger, auto_rearm;
  logic [NUM_CH-1:0] irq_enable, irq_at_start_select, channel_active_flag, irq;
  logic [NUM_CH-1:0][BURST_W-1:0] burst_size;
  logic [NUM_CH-1:0][XFER_W-1:0] transfer_size, read_wrap_size, write_wrap_size;
  logic [NUM_CH-1:0][STEP_W-1:0] read_word_step, write_word_step, read_burst_step;
  logic [NUM_CH-1:0][STEP_W-1:0] write_burst_step, read_wrap_step, write_wrap_step;
  logic [NUM_CH-1:0][ADDR_W-1:0] shadow_read_pointer, shadow_write_pointer;
  logic [NUM_CH-1:0][ADDR_W-1:0] shadow_read_circle_base_pointer;
  logic [NUM_CH-1:0][ADDR_W-1:0] shadow_write_circle_base_pointer;
  logic mem_rd_en, mem_wr_valid, mem_wr_ready;
  logic [ADDR_W-1:0] mem_rd_addr, mem_wr_addr;
  logic [DATA_W-1:0] mem_rd_data, mem_wr_data;
  logic [ADDR_W-1:0] rd_seen[$], rd_exp[$];
  logic [FIFO_W-1:0] wr_seen[$], wr_exp[$];
  logic [CH_W-1:0] order[$];
  int mismatches = 0, check_count = 0, cyc = 0;
  int irq_cyc[NUM_CH], first_rd[NUM_CH], last_rd[NUM_CH];

  always #12.5 clock = ~clock;

  dma_channel_sequencer i_dma_channel_sequencer (.clock(clock), .rst(rst),
    .preempt_mode(preempt_mode), .trigger(trigger), .run_set(run_set),
    .whole_job_per_trigger(whole_job_per_trigger), .auto_rearm(auto_rearm),
    .irq_enable(irq_enable), .irq_at_start_select(irq_at_start_select),
    .burst_size(burst_size), .transfer_size(transfer_size),
    .read_wrap_size(read_wrap_size), .write_wrap_size(write_wrap_size),
    .read_word_step(read_word_step), .write_word_step(write_word_step),
    .read_burst_step(read_burst_step), .write_burst_step(write_burst_step),
    .read_wrap_step(read_wrap_step), .write_wrap_step(write_wrap_step),
    .shadow_read_pointer(shadow_read_pointer), .shadow_write_pointer(shadow_write_pointer),
    .shadow_read_circle_base_pointer(shadow_read_circle_base_pointer),
    .shadow_write_circle_base_pointer(shadow_write_circle_base_pointer),
    .channel_active_flag(channel_active_flag), .irq(irq), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));

  dma_mem_model i_dma_mem_model (.clock(clock), .rst(rst), .slow(slow), .hold(hold),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_wr_ready(mem_wr_ready));

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // monitor of both memory sides; the address bits 18:16 carry the channel
  always @(posedge clock) begin
    cyc++;
    if (!rst && mem_rd_en === 1'b1) begin
      rd_seen.push_back(mem_rd_addr);
      order.push_back(mem_rd_addr[18:16]);
      if (first_rd[mem_rd_addr[18:16]] == 0) first_rd[mem_rd_addr[18:16]] = cyc;
      last_rd[mem_rd_addr[18:16]] = cyc;
    end
    if (!rst && mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      wr_seen.push_back({mem_wr_addr, mem_wr_data});
    end
    for (int c = 0; c < NUM_CH; c++) if (irq[c] === 1'b1) irq_cyc[c] = cyc;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [FIFO_W-1:0] e, input logic [FIFO_W-1:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  // a run pulse starts a fresh log for the test
  task automatic pulse(input logic [NUM_CH-1:0] r, input logic [NUM_CH-1:0] t);
    if (r != 6'h00) begin
      order.delete();
      for (int c = 0; c < NUM_CH; c++) {irq_cyc[c], first_rd[c], last_rd[c]} = 96'h0;
    end
    run_set <= r;
    trigger <= t;
    @(posedge clock);
    run_set <= 6'h00;
    trigger <= 6'h00;
    @(posedge clock);
  endtask

  task automatic expect_word(input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa);
    rd_exp.push_back(ra);
    wr_exp.push_back({wa, ra[DATA_W-1:0] ^ 16'hA5C3});
  endtask

  // per channel the words must come in order; channels may interleave
  task automatic judge(input string name, input int words);
    int n;
    n = 0;
    while (wr_seen.size() < words && n < 4000) begin
      @(posedge clock);
      n++;
    end
    repeat (40) @(posedge clock);
    chk("read count", FIFO_W'(words), FIFO_W'(rd_seen.size()));
    chk("write count", FIFO_W'(words), FIFO_W'(wr_seen.size()));
    while (rd_seen.size() > 0 && rd_exp.size() > 0) begin
      n = 0;
      while (n < rd_exp.size() - 1 && rd_exp[n][18:16] !== rd_seen[0][18:16]) n++;
      chk("read address", FIFO_W'(rd_exp[n]), FIFO_W'(rd_seen.pop_front()));
      rd_exp.delete(n);
    end
    while (wr_seen.size() > 0 && wr_exp.size() > 0) begin
      n = 0;
      while (n < wr_exp.size() - 1 && wr_exp[n][34:32] !== wr_seen[0][34:32]) n++;
      chk("write address and data", wr_exp[n], wr_seen.pop_front());
      wr_exp.delete(n);
    end
    rd_seen.delete();
    rd_exp.delete();
    wr_seen.delete();
    wr_exp.delete();
    $display("test %s done", name);
  endtask

  task automatic test_single;
    read_word_step[1] <= 16'h0002;
    write_word_step[1] <= 16'hFFFF;
    burst_size[1] <= 5'h03;
    irq_at_start_select[1] <= 1'b1;
    pulse(6'h02, 6'h00);
    pulse(6'h00, 6'h02);
    for (int i = 0; i < 4; i++) expect_word(22'h010000 + 22'(2 * i), 22'h018000 - 22'(i));
    judge("single burst", 4);
    chk("irq at start", 1, irq_cyc[1] > 0 && irq_cyc[1] < first_rd[1]);
    chk("flag cleared", 0, FIFO_W'(channel_active_flag[1]));
    pulse(6'h00, 6'h02);
    judge("trigger while stopped", 0);
  endtask

  task automatic test_whole_wrap;
    logic [ADDR_W-1:0] starts[5];
    int n;
    starts = '{22'h020000, 22'h020014, 22'h021100, 22'h021114, 22'h021200};
    burst_size[2] <= 5'h03;
    transfer_size[2] <= 16'h0004;
    whole_job_per_trigger[2] <= 1'b1;
    auto_rearm[2] <= 1'b1;
    read_burst_step[2] <= 16'h0010;
    read_wrap_size[2] <= 16'h0001;
    read_wrap_step[2] <= 16'h0100;
    hold <= 1'b1;
    pulse(6'h04, 6'h00);
    pulse(6'h00, 6'h04);
    n = 0;
    while (rd_seen.size() == 0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    // a new shadow must wait for the next transfer
    shadow_read_pointer[2] <= 22'h02F000;
    repeat (80) @(posedge clock);
    chk("reads stall on full fifo", 1, rd_seen.size() >= 16 && rd_seen.size() <= 18);
    hold <= 1'b0;
    slow <= 1'b1;
    for (int b = 0; b < 5; b++) begin
      for (int w = 0; w < 4; w++) expect_word(starts[b] + 22'(w), 22'h028000 + 22'(4 * b + w));
    end
    judge("whole job with wrap", 20);
    chk("irq at end", 1, irq_cyc[2] > last_rd[2]);
    chk("flag kept", 1, FIFO_W'(channel_active_flag[2]));
    slow <= 1'b0;
  endtask

  task automatic test_rotation;
    logic [11:0] seq;
    preempt_mode <= 1'b1;
    burst_size[1] <= 5'h00;
    transfer_size[1] <= 16'h0001;
    transfer_size[5] <= 16'h0001;
    pulse(6'h22, 6'h00);
    pulse(6'h00, 6'h22);
    pulse(6'h00, 6'h22);
    // the second trigger only re-pends ch5; ch1 needs one after its first burst
    repeat (4) @(posedge clock);
    pulse(6'h00, 6'h02);
    expect_word(22'h050000, 22'h058000);
    expect_word(22'h050001, 22'h058001);
    expect_word(22'h010000, 22'h018000);
    expect_word(22'h010002, 22'h017FFF);
    judge("rotation", 4);
    seq = 12'h0;
    foreach (order[i]) seq = {seq[8:0], order[i]};
    chk("service order", 12'hA69, FIFO_W'(seq));
    chk("flags after two bursts", 0, FIFO_W'(channel_active_flag & 6'h22));
  endtask

  task automatic test_preempt;
    int n;
    burst_size[3] <= 5'h07;
    burst_size[0] <= 5'h01;
    pulse(6'h09, 6'h00);
    pulse(6'h00, 6'h08);
    n = 0;
    while (rd_seen.size() < 2 && n < 50) begin
      @(posedge clock);
      n++;
    end
    pulse(6'h00, 6'h01);
    for (int i = 0; i < 8; i++) expect_word(22'h030000 + 22'(i), 22'h038000 + 22'(i));
    expect_word(22'h000000, 22'h008000);
    expect_word(22'h000001, 22'h008001);
    judge("preemption", 10);
    n = 0;
    while (n < order.size() - 1 && order[n] !== 3'h0) n++;
    chk("suspend point", 1, n >= 2 && n <= 6 && order[n + 1] === 3'h0);
  endtask

  initial begin
    {trigger, run_set, whole_job_per_trigger, auto_rearm, irq_at_start_select} = '0;
    irq_enable = 6'h3F;
    burst_size = '0;
    transfer_size = '0;
    {read_wrap_size, write_wrap_size} = '1;
    {read_word_step, write_word_step} = {12{16'h0001}};
    {read_burst_step, write_burst_step, read_wrap_step, write_wrap_step} = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      shadow_read_pointer[c] = {3'h0, 3'(c), 16'h0000};
      shadow_write_pointer[c] = {3'h0, 3'(c), 16'h8000};
      shadow_read_circle_base_pointer[c] = {3'h0, 3'(c), 16'h1000};
      shadow_write_circle_base_pointer[c] = {3'h0, 3'(c), 16'h9000};
    end
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_single();
    test_whole_wrap();
    test_rotation();
    test_preempt();
    test_done();
  end
endmodule // testbench
